//--- rtl/cam_follower.sv
// Electronic cam engine: one master axis taken from a main encoder drives up
// to three slave axes through a position table at uniform master intervals.
// Assumes encoder counts and commands are synchronous to clk; the servo loops
// take slave_pos as their command when the matching engaged bit is high.
`timescale 1ns/1ps

module cam_follower
  import cam_follower_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  srst,
  input  wire logic                                  clk_en,
  input  wire logic [`CAM_NUM_AXES*`CAM_POS_W-1:0]   enc_pos,
  input  wire logic                                  cmd_valid,
  input  wire cam_cmd_type                           cmd,
  output      logic                                  cmd_ready,
  output      logic                                  cmd_reject_ff,
  output      logic [`CAM_NUM_SLAVES*`CAM_POS_W-1:0] slave_pos,
  output      logic [`CAM_NUM_SLAVES*`CAM_POS_W-1:0] cam_cycle_readback,
  output      cam_status_type                        status
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Non-negative remainder; a zero modulus leaves the value untouched.
  function automatic pos_type f_mod(input pos_type v, input pos_type m);
    logic signed [`CAM_POS_W:0] r;
    r = '0;
    if (m == '0) begin
      return v;
    end
    r = $signed({v[`CAM_POS_W-1], v}) % $signed({1'b0, m});
    if (r < 0) begin
      r = r + $signed({1'b0, m});
    end
    return r[`CAM_POS_W-1:0];
  endfunction : f_mod

  // True when the master passed pt moving from prev to cur, wrap included.
  function automatic logic f_crossed(input logic [`CAM_MCYC_W-1:0] prev,
                                     input logic [`CAM_MCYC_W-1:0] cur,
                                     input logic [`CAM_MCYC_W-1:0] pt);
    if (prev == cur) begin
      return 1'b0;
    end else if (prev < cur) begin
      return (pt > prev) && (pt <= cur);
    end else begin
      return (pt > prev) || (pt <= cur);
    end
  endfunction : f_crossed

  // A point counts as inside the cycle when it is non-negative and below it.
  function automatic logic f_in_cycle(input pos_type pt, input logic [`CAM_MCYC_W-1:0] cyc);
    return (pt[`CAM_POS_W-1] == 1'b0) && (pt < {9'h000, cyc});
  endfunction : f_in_cycle

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic                           mode_on_ff;
  logic [1:0]                     pick_ff;
  logic [`CAM_MCYC_W-1:0]         mcycle_ff;
  logic [`CAM_MCYC_W-1:0]         interval_ff;
  logic [`CAM_MCYC_W-1:0]         origin_ff;
  pos_type                        change_ff    [`CAM_NUM_SLAVES];
  pos_type                        table_ff     [`CAM_TABLE_POINTS][`CAM_NUM_SLAVES];
  logic [`CAM_MCYC_W-1:0]         engage_pt_ff [`CAM_NUM_SLAVES];
  logic [`CAM_MCYC_W-1:0]         release_pt_ff[`CAM_NUM_SLAVES];
  logic [`CAM_NUM_SLAVES-1:0]     engage_arm_ff;
  logic [`CAM_NUM_SLAVES-1:0]     release_arm_ff;
  logic [`CAM_NUM_SLAVES-1:0]     engaged_ff;
  pos_type                        slave_pos_ff [`CAM_NUM_SLAVES];
  pos_type                        enc_prev_ff;
  logic [`CAM_MCYC_W-1:0]         master_ff;
  logic [`CAM_MCYC_W-1:0]         nxt_master;
  logic                           wrap_fwd;
  pos_type                        enc_sel;
  pos_type                        delta;
  logic signed [`CAM_POS_W:0]     sum;
  logic [`CAM_MCYC_W-1:0]         rel;
  logic [`CAM_IDX_W-1:0]          seg_idx;
  logic [`CAM_MCYC_W-1:0]         seg_frac;
  logic [`CAM_MCYC_W-1:0]         seg_q;
  pos_type                        interp    [`CAM_NUM_SLAVES];
  logic                           do_cmd;
  logic                           bad_limit;

  assign cmd_ready = 1'b1; // Every command is taken in one cycle.
  assign do_cmd    = cmd_valid && clk_en;

  // Master source select; only the main encoder counts are wired in.
  assign enc_sel = enc_pos[pick_ff*`CAM_POS_W +: `CAM_POS_W];

  // ---------------------------------------------------------------------------
  // Master position tracking
  // ---------------------------------------------------------------------------
  // Movement per cycle is assumed smaller than one master cycle.
  always_comb begin
    delta      = enc_sel - enc_prev_ff;
    sum        = $signed({10'h000, master_ff}) + $signed({delta[`CAM_POS_W-1], delta});
    wrap_fwd   = 1'b0;
    nxt_master = master_ff;
    if (mcycle_ff == '0) begin
      nxt_master = '0;
    end else if (master_ff >= mcycle_ff) begin
      // A shrunken cycle folds a stale position straight back inside it.
      nxt_master = 23'(f_mod(sum[`CAM_POS_W-1:0], {9'h000, mcycle_ff}));
    end else if (sum >= $signed({10'h000, mcycle_ff})) begin
      nxt_master = 23'(sum - $signed({10'h000, mcycle_ff}));
      wrap_fwd   = 1'b1;
    end else if (sum < 0) begin
      nxt_master = 23'(sum + $signed({10'h000, mcycle_ff}));
    end else begin
      nxt_master = sum[`CAM_MCYC_W-1:0];
    end
  end

  // Master register; the index set command moves it onto a table point.
  always_ff @(posedge clk) begin
    if (srst) begin
      master_ff   <= '0;
      enc_prev_ff <= '0;
    end else if (clk_en) begin
      enc_prev_ff <= enc_sel;
      if (do_cmd && cmd.op == OP_INDEX_SET) begin
        master_ff <= 23'(({14'h0000, cmd.index} * interval_ff + origin_ff) %
                         ((mcycle_ff == '0) ? 23'h00_0001 : mcycle_ff));
      end else if (do_cmd && cmd.op == OP_MASTER_PICK) begin
        // A new master source starts from its own count, so nothing jumps.
        enc_prev_ff <= enc_pos[cmd.axis*`CAM_POS_W +: `CAM_POS_W];
      end else begin
        master_ff <= nxt_master;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Segment lookup
  // ---------------------------------------------------------------------------
  // Position relative to the first table entry, then split into index and fraction.
  always_comb begin
    rel = (master_ff >= origin_ff) ? master_ff - origin_ff
                                   : master_ff + mcycle_ff - origin_ff;
    // The quotient is capped at full width; cutting it to the index first would alias.
    if (interval_ff == '0) begin
      seg_q    = '0;
      seg_frac = '0;
    end else begin
      seg_q    = rel / interval_ff;
      seg_frac = rel % interval_ff;
    end
    if (seg_q >= 23'(`CAM_MAX_INTERVALS)) begin
      seg_idx  = 9'(`CAM_MAX_INTERVALS - 1); // The last point closes the table.
      seg_frac = interval_ff;
    end else begin
      seg_idx  = seg_q[`CAM_IDX_W-1:0];
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < `CAM_NUM_SLAVES; gs++) begin : g_slave
      cam_segment_interp u_interp (
        .y_lo  (table_ff[seg_idx][gs]),
        .y_hi  (table_ff[seg_idx + 9'h001][gs]),
        .frac  (seg_frac),
        .width (interval_ff),
        .y_out (interp[gs])
      );
      assign slave_pos[gs*`CAM_POS_W +: `CAM_POS_W]          = slave_pos_ff[gs];
      assign cam_cycle_readback[gs*`CAM_POS_W +: `CAM_POS_W] = change_ff[gs];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Configuration commands
  // ---------------------------------------------------------------------------
  // Axis 0 of a cycle command sets the master, axes 1..3 the slave changes.
  assign bad_limit = (cmd.op == OP_CYCLE) &&
                     (((cmd.axis == 2'h0) && (cmd.data > `CAM_MASTER_CYC_MAX)) ||
                      ((cmd.axis != 2'h0) && (cmd.data > `CAM_SLAVE_CHG_MAX)));

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_on_ff    <= 1'b0;
      pick_ff       <= `CAM_RST_PICK;
      mcycle_ff     <= `CAM_RST_MCYCLE;
      interval_ff   <= `CAM_RST_INTERVAL;
      origin_ff     <= `CAM_RST_ORIGIN;
      cmd_reject_ff <= 1'b0;
      for (int i = 0; i < `CAM_NUM_SLAVES; i++) begin
        change_ff[i] <= '0;
      end
    end else if (clk_en) begin
      cmd_reject_ff <= do_cmd && bad_limit;
      if (do_cmd && !bad_limit) begin
        unique case (cmd.op)
          OP_MASTER_PICK: begin
            pick_ff <= cmd.axis;
          end
          OP_CYCLE: begin
            if (cmd.axis == 2'h0) begin
              mcycle_ff <= cmd.data[`CAM_MCYC_W-1:0];
            end else begin
              change_ff[cmd.axis - 2'h1] <= cmd.data;
            end
          end
          OP_INTERVAL: begin
            interval_ff <= cmd.data[`CAM_MCYC_W-1:0];
          end
          OP_ORIGIN: begin
            origin_ff <= cmd.data[`CAM_MCYC_W-1:0];
          end
          OP_MODE: begin
            mode_on_ff <= cmd.data[0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Table writes; no reset so the array maps onto plain memory.
  always_ff @(posedge clk) begin
    if (clk_en && do_cmd && cmd.op == OP_TABLE_POINT && cmd.axis != 2'h0 &&
        cmd.index < 9'(`CAM_TABLE_POINTS)) begin
      table_ff[cmd.index][cmd.axis - 2'h1] <= cmd.data;
    end
  end

  // ---------------------------------------------------------------------------
  // Engage and release
  // ---------------------------------------------------------------------------
  // Points are stored per slave; out-of-cycle points act on the command cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      engage_arm_ff  <= '0;
      release_arm_ff <= '0;
      engaged_ff     <= '0;
      for (int i = 0; i < `CAM_NUM_SLAVES; i++) begin
        engage_pt_ff[i]  <= '0;
        release_pt_ff[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < `CAM_NUM_SLAVES; i++) begin
        // A switch-off command drops every slave on the edge that takes it.
        if (!mode_on_ff || (do_cmd && cmd.op == OP_MODE && !cmd.data[0])) begin
          engaged_ff[i] <= 1'b0;
        end else if (engage_arm_ff[i] && f_crossed(master_ff, nxt_master, engage_pt_ff[i])) begin
          engaged_ff[i]    <= 1'b1;
          engage_arm_ff[i] <= 1'b0;
        end else if (release_arm_ff[i] &&
                     f_crossed(master_ff, nxt_master, release_pt_ff[i])) begin
          engaged_ff[i]     <= 1'b0;
          release_arm_ff[i] <= 1'b0;
        end
        if (do_cmd && cmd.axis == 2'(i + 1) && cmd.op == OP_ENGAGE) begin
          engage_pt_ff[i] <= cmd.data[`CAM_MCYC_W-1:0];
          if (!f_in_cycle(cmd.data, mcycle_ff)) begin
            engaged_ff[i]    <= mode_on_ff;
            engage_arm_ff[i] <= 1'b0;
          end else begin
            engage_arm_ff[i] <= 1'b1;
          end
        end
        if (do_cmd && cmd.axis == 2'(i + 1) && cmd.op == OP_RELEASE) begin
          release_pt_ff[i] <= cmd.data[`CAM_MCYC_W-1:0];
          if (!f_in_cycle(cmd.data, mcycle_ff)) begin
            engaged_ff[i]     <= 1'b0;
            release_arm_ff[i] <= 1'b0;
            engage_arm_ff[i]  <= 1'b0;
          end else begin
            release_arm_ff[i] <= 1'b1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Slave command positions
  // ---------------------------------------------------------------------------
  // An engaged slave takes the table value folded into its change, so the end
  // of the cycle lands on zero; a newly engaged slave is folded the same way.
  // The host is expected to preposition the slave, since no ramp is applied.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `CAM_NUM_SLAVES; i++) begin
        slave_pos_ff[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < `CAM_NUM_SLAVES; i++) begin
        if (engaged_ff[i] && wrap_fwd) begin
          slave_pos_ff[i] <= f_mod(table_ff[0][i], change_ff[i]);
        end else if (engaged_ff[i]) begin
          slave_pos_ff[i] <= f_mod(interp[i], change_ff[i]);
        end else begin
          slave_pos_ff[i] <= slave_pos_ff[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status readback
  // ---------------------------------------------------------------------------
  always_comb begin
    status.mode_on       = mode_on_ff;
    status.index         = seg_idx;
    status.master_cycle  = mcycle_ff;
    status.interval      = interval_ff;
    status.master_pos    = master_ff;
    status.engaged       = engaged_ff;
    status.release_armed = release_arm_ff;
  end

endmodule : cam_follower

//--- common/cam_follower_defs.svh
// Constants of the table-driven cam follower: widths, limits and reset values.
// Assumes inclusion by bare name from the package, compiled ahead of the design modules.
`ifndef CAM_FOLLOWER_DEFS_SVH
`define CAM_FOLLOWER_DEFS_SVH

`define CAM_NUM_AXES        4
`define CAM_NUM_SLAVES      3
`define CAM_TABLE_POINTS    257
`define CAM_MAX_INTERVALS   256
`define CAM_POS_W           32
`define CAM_MCYC_W          23
`define CAM_IDX_W           9
`define CAM_MASTER_CYC_MAX  32'h007F_FFFF
`define CAM_SLAVE_CHG_MAX   32'h7FFF_FFFF
`define CAM_RST_MCYCLE      23'h00_0000
`define CAM_RST_INTERVAL    23'h00_0001
`define CAM_RST_ORIGIN      23'h00_0000
`define CAM_RST_PICK        2'h0

`endif

//--- common/cam_follower_pkg.sv
// Types shared by the cam follower: command opcodes and command/status carriers.
// Assumes the constants header sits on the include path.
`include "cam_follower_defs.svh"

package cam_follower_pkg;

  // --------------------------------------------------------------------------
  // Command set
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_MASTER_PICK = 4'h0,
    OP_CYCLE       = 4'h1,
    OP_INTERVAL    = 4'h2,
    OP_ORIGIN      = 4'h3,
    OP_TABLE_POINT = 4'h4,
    OP_MODE        = 4'h5,
    OP_ENGAGE      = 4'h6,
    OP_RELEASE     = 4'h7,
    OP_INDEX_SET   = 4'h8
  } cam_op_type;

  typedef struct packed {
    cam_op_type                  op;
    logic [1:0]                  axis;
    logic [`CAM_IDX_W-1:0]       index;
    logic [`CAM_POS_W-1:0]       data;
  } cam_cmd_type;

  typedef logic [`CAM_POS_W-1:0] pos_type;

  typedef struct packed {
    logic                        mode_on;
    logic [`CAM_IDX_W-1:0]       index;
    logic [`CAM_MCYC_W-1:0]      master_cycle;
    logic [`CAM_MCYC_W-1:0]      interval;
    logic [`CAM_MCYC_W-1:0]      master_pos;
    logic [`CAM_NUM_SLAVES-1:0]  engaged;
    logic [`CAM_NUM_SLAVES-1:0]  release_armed;
  } cam_status_type;

endpackage : cam_follower_pkg

//--- rtl/cam_segment_interp.sv
// Linear interpolation between two table points of one slave.
// Assumes the caller keeps frac at or below width and registers the result.
`timescale 1ns/1ps

module cam_segment_interp
  import cam_follower_pkg::*;
(
  input  wire logic [`CAM_POS_W-1:0]  y_lo,
  input  wire logic [`CAM_POS_W-1:0]  y_hi,
  input  wire logic [`CAM_MCYC_W-1:0] frac,
  input  wire logic [`CAM_MCYC_W-1:0] width,
  output      logic [`CAM_POS_W-1:0]  y_out
);

  logic signed [`CAM_POS_W:0]      span;
  logic signed [`CAM_POS_W+24:0]   prod;
  logic signed [`CAM_POS_W+24:0]   step;

  // ---------------------------------------------------------------------------
  // Interpolation
  // ---------------------------------------------------------------------------
  // Span is one bit wider so a full-range step between points cannot overflow.
  always_comb begin
    span = $signed({y_hi[`CAM_POS_W-1], y_hi}) - $signed({y_lo[`CAM_POS_W-1], y_lo});
    prod = span * $signed({2'b00, frac});
    if (width == '0) begin
      step = '0; // A zero width cannot be divided; the low point is held.
    end else begin
      step = prod / $signed({2'b00, width});
    end
    y_out = y_lo + step[`CAM_POS_W-1:0];
  end

endmodule : cam_segment_interp

//--- verif/encoder_bank.sv
// Behavioural bank of four main encoders that feeds the cam follower.
// Assumes the bench changes step off the rising edge of clk.
`timescale 1ns/1ps

module encoder_bank (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [31:0]  step,
  output      logic [127:0] enc_pos
);
  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  // Axis a moves by step*(a+1), so a wrong master pick shows up at once.
  always_ff @(posedge clk) begin
    for (int a = 0; a < 4; a++) begin
      if (srst)
        enc_pos[a*32 +: 32] <= 32'h0000_0000;
      else
        enc_pos[a*32 +: 32] <= enc_pos[a*32 +: 32] + 32'(step * (a + 1));
    end
  end
endmodule : encoder_bank

//--- verif/cam_follower_assertions.sv
// Port-level checks of the cam follower, bound into every instance.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module cam_follower_checker
  import cam_follower_pkg::*;
(
  input wire logic           clk,
  input wire logic           srst,
  input wire logic           clk_en,
  input wire logic           cmd_valid,
  input wire cam_cmd_type    cmd,
  input wire logic           cmd_reject_ff,
  input wire logic [95:0]    slave_pos,
  input wire logic [95:0]    cam_cycle_readback,
  input wire cam_status_type status
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // A command only counts when the clock enable lets it in.
  logic go;
  assign go = cmd_valid & clk_en;

  AST_MODE_ON:
    assert property (go && cmd.op == OP_MODE && cmd.data[0] |=> status.mode_on)
    else $error("mode switch on was not obeyed");
  AST_MODE_OFF:
    assert property (go && cmd.op == OP_MODE && !cmd.data[0]
                     |=> !status.mode_on && status.engaged == 3'h0)
    else $error("mode switch off was not obeyed");
  AST_OFF_DISENGAGED:
    assert property (!status.mode_on |-> status.engaged == 3'h0)
    else $error("slave engaged while mode is off");
  AST_MCYC_REJECT:
    assert property (go && cmd.op == OP_CYCLE && cmd.axis == 2'h0 && cmd.data > 32'h007F_FFFF
                     |=> cmd_reject_ff && $stable(status.master_cycle))
    else $error("oversized master cycle was taken");
  AST_SCHG_ACCEPT:
    assert property (go && cmd.op == OP_CYCLE && cmd.axis == 2'h1 && !cmd.data[31]
                     |=> !cmd_reject_ff && cam_cycle_readback[31:0] == $past(cmd.data))
    else $error("legal slave change was not stored");
  AST_MASTER_WRAP:
    assert property ($stable(status.master_cycle) && status.master_cycle != 23'h0
                     |-> status.master_pos < status.master_cycle)
    else $error("master position outside its cycle");
  AST_ENGAGE_NOW:
    assert property (status.mode_on && go && cmd.op == OP_ENGAGE && cmd.axis == 2'h1
                     && cmd.data[31] |=> status.engaged[0])
    else $error("out-of-cycle engage did not act at once");
  AST_RELEASE_NOW:
    assert property (go && cmd.op == OP_RELEASE && cmd.axis == 2'h1 && cmd.data[31]
                     |=> !status.engaged[0])
    else $error("out-of-cycle release did not act at once");
  AST_IDLE_HOLDS:
    assert property (!status.engaged[0] && !(go && cmd.op == OP_ENGAGE)
                     |=> $stable(slave_pos[31:0]))
    else $error("disengaged slave moved");
endmodule : cam_follower_checker

bind cam_follower cam_follower_checker u_chk (
  .clk(clk), .srst(srst), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_reject_ff(cmd_reject_ff), .slave_pos(slave_pos),
  .cam_cycle_readback(cam_cycle_readback), .status(status)
);

//--- verif/testbench.sv
// Self-checking bench for the cam follower with an integer reference model.
// Assumes the encoder bank and the bound checker are compiled alongside.
`timescale 1ns/1ps

module testbench;
  import cam_follower_pkg::*;
  localparam int CYC = 6000;
  localparam int IVL = 2000;
  localparam int CHG = 4000;
  logic           clk;
  logic           srst;
  logic           clk_en;
  logic           cmd_valid;
  cam_cmd_type    cmd;
  logic [31:0]    step;
  logic [127:0]   enc_pos;
  logic           cmd_ready;
  logic           cmd_reject_ff;
  logic [95:0]    slave_pos;
  logic [95:0]    cam_cycle_readback;
  cam_status_type status;
  logic           last_rej;
  int             miscompares;
  int             num_checks;
  int             m;
  int             pick;
  int             tbl [0:3] = '{0, 1000, 3000, 3600};

  // ----------------------------------------------------------------
  // Clock, far side and design
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  encoder_bank enc (.clk(clk), .srst(srst), .step(step), .enc_pos(enc_pos));

  cam_follower dut (.clk(clk), .srst(srst), .clk_en(clk_en), .enc_pos(enc_pos),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .cmd_reject_ff(cmd_reject_ff), .slave_pos(slave_pos),
    .cam_cycle_readback(cam_cycle_readback), .status(status));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Two cycles per command keep valid from toggling twice in one step.
  task automatic send(input cam_op_type op, input logic [1:0] ax, input int idx,
                      input logic [31:0] d);
    cmd.op = op;
    cmd.axis = ax;
    cmd.index = idx[8:0];
    cmd.data = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    last_rej = cmd_reject_ff;
    @(negedge clk);
  endtask : send

  // One cycle of encoder motion, then time for master and slave to settle.
  task automatic move(input int d);
    step = d;
    @(negedge clk);
    step = 32'h0000_0000;
    m = (m + d * (pick + 1)) % CYC;
    repeat (4) @(negedge clk);
  endtask : move

  // Reference: linear table interpolation folded by the slave change.
  function automatic int exp_pos(input int mp);
    int k;
    int y;
    k = mp / IVL;
    y = tbl[k] + (tbl[k + 1] - tbl[k]) * (mp % IVL) / IVL;
    return y % CHG;
  endfunction : exp_pos

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    step = 32'h0000_0000;
    m = 0;
    void'($urandom(93));
    repeat (6) @(negedge clk);
    srst = 1'b0;
    check(status.mode_on, 0);
    check(status.interval, 1);
    check(status.master_cycle, 0);
    check(slave_pos[31:0], 0);
    check(cmd_ready, 1);
    // With the enable low a command must leave no trace.
    clk_en = 1'b0;
    send(OP_MODE, 2'h0, 0, 1);
    check(status.mode_on, 0);
    clk_en = 1'b1;
    // Limits on both sides of each bound, refused ones leave the old value.
    for (int i = 0; i < 4; i++) begin
      send(OP_CYCLE, i < 2 ? 2'h0 : 2'h1, 0, (i < 2 ? 32'h007F_FFFF : 32'h7FFF_FFFF) + i % 2);
      check(last_rej, i % 2);
      check(i < 2 ? status.master_cycle : cam_cycle_readback[31:0],
            i < 2 ? 32'h007F_FFFF : 32'h7FFF_FFFF);
    end
    send(OP_CYCLE, 2'h0, 0, CYC);
    send(OP_CYCLE, 2'h1, 0, CHG);
    // A falling profile of 1500 counts is entered by its magnitude.
    send(OP_CYCLE, 2'h2, 0, 1500);
    check(cam_cycle_readback[63:32], 1500);
    pick = $urandom_range(3, 0);
    send(OP_MASTER_PICK, 2'(pick), 0, 0);
    send(OP_INTERVAL, 2'h0, 0, IVL);
    send(OP_ORIGIN, 2'h0, 0, 0);
    check(status.interval, IVL);
    check(status.master_cycle, CYC);
    for (int k = 0; k < 4; k++)
      send(OP_TABLE_POINT, 2'h1, k, tbl[k]);
    send(OP_TABLE_POINT, 2'h1, 257, 32'h0000_0777);
    send(OP_MODE, 2'h0, 0, 1);
    check(status.mode_on, 1);
    // The slave already sits at the table value for master 0, so no jump.
    send(OP_ENGAGE, 2'h1, 0, 32'hFFFF_FFFF);
    send(OP_ENGAGE, 2'h3, 0, 32'hFFFF_FFFF);
    check(status.engaged, 3'b101);
    check(slave_pos[31:0], 0);
    for (int n = 0; n < 12; n++) begin
      move($urandom_range(600, 1));
      check(status.master_pos, m);
      check(status.index, m / IVL);
      check(slave_pos[31:0], exp_pos(m));
    end
    send(OP_INDEX_SET, 2'h0, 2, 0);
    m = 2 * IVL;
    check(status.master_pos, m);
    check(slave_pos[31:0], exp_pos(m));
    send(OP_RELEASE, 2'h1, 0, 5000);
    check(status.release_armed, 3'b001);
    move(1500 / (pick + 1));
    check(status.engaged[0], 0);
    check(slave_pos[31:0], exp_pos(4000));
    move(100);
    check(slave_pos[31:0], exp_pos(4000));
    send(OP_INDEX_SET, 2'h0, 0, 0);
    m = 0;
    send(OP_ENGAGE, 2'h1, 0, 1000);
    check(status.engaged[0], 0);
    move(1500 / (pick + 1));
    check(status.engaged[0], 1);
    check(slave_pos[31:0], exp_pos(m));
    send(OP_RELEASE, 2'h1, 0, 32'hFFFF_FFFF);
    check(status.engaged[0], 0);
    send(OP_MODE, 2'h0, 0, 0);
    check(status.engaged, 0);
    check(status.mode_on, 0);
    check(slave_pos[63:32], 0);
    give_verdict;
  end

  // The scenarios need well under 1000 cycles; this cuts a hang short.
  initial begin
    #20000;
    miscompares++;
    give_verdict;
  end
endmodule : testbench
